// file: src/eeprom_link_pkg.sv
// Constants and types shared by the two-wire serial EEPROM slave
package eeprom_link_pkg;

  // Array organisation
  localparam int MEM_ADDR_W = 12;
  localparam int PAGE_OFFS_W = 5;
  localparam int BYTE_W = 8;

  // Device address word layout
  localparam logic [3:0] DEV_TYPE_CODE = 4'ha;
  localparam int DEV_TYPE_MSB = 7;
  localparam int DEV_TYPE_LSB = 4;
  localparam int DEV_SEL_MSB = 3;
  localparam int DEV_SEL_LSB = 1;
  localparam int DEV_RW_BIT = 0;
  localparam int STRAP_W = 3;

  // Bit slots inside one nine-clock word
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] BIT_STEP = 4'h1;

  // Self-timed programming cycle, longest time rounds down
  localparam int PROGRAM_CYCLE_TIME_MS = 5;
  localparam int REF_CLK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int PROGRAM_CYCLE_COUNT = PROGRAM_CYCLE_TIME_MS * (REF_CLK_HZ / MS_PER_S);

  // Link side word decoder states
  typedef enum logic [2:0] {
    ls_device,
    ls_addr_hi,
    ls_addr_lo,
    ls_write,
    ls_read,
    ls_ignore
  } link_state_type;

  // Programming sequencer states
  typedef enum logic [1:0] {
    ps_idle,
    ps_copy,
    ps_wait
  } prog_state_type;

endpackage

// file: src/eeprom_link_slave.sv
// Two-wire serial EEPROM slave: bus engine on the serial clock, array and programming on ref_clk
//
// Function
// - Data changes only while clock low; changes while clock high are START or STOP.
// - Data falling with clock high is START; it begins a new transaction.
// - Data rising with clock high is STOP; it ends the current transaction.
// - Words are eight bits; device drives acknowledge low in the ninth clock.
// - Standby after power-up, after STOP ending a read, after programming completes.
// - START, nine clocks, START then STOP leaves the device idle and ready.
// - First word after START is device address: type 1010, select, read flag.
// - Received select bits must equal the three strap pin levels.
// - Unconnected strap pins count as logic low; the code has no pull-down and samples the strap pins unchanged.
// - Read flag set starts a read, clear starts a write.
// - Match gives acknowledge; mismatch gives none and waits in standby for START.
// - Write sends two address bytes: low nibble of first, then low byte.
// - Byte write: acknowledge all, STOP starts self-timed programming, inputs ignored meanwhile.
// - Page write: more data bytes before STOP, each acknowledged.
// - Page write increments only low five address bits, wrapping inside the page.
// - During programming the device address is not acknowledged; polling sees completion.
// - Address counter holds last accessed address plus one across transactions.
// - Reading past the last array byte wraps the counter to zero.
// - Current-address read shifts out the byte at the counter; controller NACKs, STOPs.
// - Random read: dummy write of address, repeated START, read-flagged device address.
// - Sequential read: each controller acknowledge advances and sends the next byte.
// - Write-protect high inhibits programming of the whole array.
// - Inputs sampled on rising clock edge; outputs change after falling edge.
// - Programming cycle completes within five milliseconds.
// - Write-protect low or open allows normal writes; the code has no pull-down, so only a sampled low allows them.
`timescale 1ns/1ps

module eeprom_link_slave #(
  parameter int MEM_ADDR_W = eeprom_link_pkg::MEM_ADDR_W,
  parameter int PAGE_OFFS_W = eeprom_link_pkg::PAGE_OFFS_W,
  parameter int PROG_CYCLES = eeprom_link_pkg::PROGRAM_CYCLE_COUNT
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic strap_select_bit2,
  input wire logic strap_select_bit1,
  input wire logic strap_select_bit0,
  input wire logic write_protect,
  output logic standby,
  output logic program_active
);
  import eeprom_link_pkg::*;

  localparam int MEM_DEPTH = 1 << MEM_ADDR_W;
  localparam int PAGE_BYTES = 1 << PAGE_OFFS_W;
  localparam int PAGE_W = MEM_ADDR_W - PAGE_OFFS_W;
  localparam int ADDR_HI_W = MEM_ADDR_W - BYTE_W;
  localparam int TIMER_W = $clog2(PROG_CYCLES + 1);
  localparam logic [TIMER_W-1:0] WAIT_LOAD = TIMER_W'(PROG_CYCLES - PAGE_BYTES - 1);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = '0;
  localparam logic [TIMER_W-1:0] TIMER_STEP = TIMER_W'(1);
  localparam logic [PAGE_OFFS_W-1:0] OFFS_LAST = '1;
  localparam logic [PAGE_OFFS_W-1:0] OFFS_STEP = PAGE_OFFS_W'(1);
  localparam logic [MEM_ADDR_W-1:0] ADDR_STEP = MEM_ADDR_W'(1);
  localparam int PIN_W = 6;
  localparam int PIN_SCL = 5;
  localparam int PIN_SDA = 4;
  localparam int PIN_WP = 3;
  localparam int LNK_W = 2;
  localparam int LNK_ARMED = 1;
  localparam int LNK_COMMIT = 0;
  localparam int XS_W = STRAP_W + 1;
  localparam int XS_BUSY = STRAP_W;

  // Full device address check against the straps, refused while programming
  function automatic logic dev_word_match(input logic [BYTE_W-1:0] word,
                                          input logic [STRAP_W-1:0] straps,
                                          input logic busy);
    dev_word_match = (word[DEV_TYPE_MSB:DEV_TYPE_LSB] == DEV_TYPE_CODE) &&
                     (word[DEV_SEL_MSB:DEV_SEL_LSB] == straps) && !busy;
  endfunction

  // ---------------------------------------------------------------
  // Reference clock domain: pin synchronisers and bus condition detect
  // ---------------------------------------------------------------
  logic [PIN_W-1:0] pin_meta_reg;
  logic [PIN_W-1:0] pin_sync_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [LNK_W-1:0] lnk_meta_reg;
  logic [LNK_W-1:0] lnk_sync_reg;
  logic start_pulse_reg;
  logic stop_pulse_reg;
  logic start_det;
  logic stop_det;
  logic link_rst_b;

  // Two-stage capture of the pins; no pull-down, so floating straps and write-protect arrive as sampled, not forced low
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else begin
      pin_meta_reg <= {scl_clk, sda_in, write_protect,
                       strap_select_bit2, strap_select_bit1, strap_select_bit0};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // Previous synchronised line levels for edge detection
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_prev_reg <= 1'h0;
      sda_prev_reg <= 1'h0;
    end else begin
      scl_prev_reg <= pin_sync_reg[PIN_SCL];
      sda_prev_reg <= pin_sync_reg[PIN_SDA];
    end
  end

  // Data edge while clock stays high is a bus condition, not data
  assign start_det = pin_sync_reg[PIN_SCL] && scl_prev_reg &&
                     sda_prev_reg && !pin_sync_reg[PIN_SDA];
  assign stop_det = pin_sync_reg[PIN_SCL] && scl_prev_reg &&
                    !sda_prev_reg && pin_sync_reg[PIN_SDA];

  // One-cycle condition pulses that restart the link engine
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      start_pulse_reg <= 1'h0;
      stop_pulse_reg <= 1'h0;
    end else begin
      start_pulse_reg <= start_det;
      stop_pulse_reg <= stop_det;
    end
  end

  // Engine restart on power-up, START or STOP; aborts any half-received byte
  assign link_rst_b = rst_b && !start_pulse_reg && !stop_pulse_reg;

  // Link status levels brought into this domain
  logic armed_reg;
  logic commit_ok_reg;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lnk_meta_reg <= '0;
      lnk_sync_reg <= '0;
    end else begin
      lnk_meta_reg <= {armed_reg, commit_ok_reg};
      lnk_sync_reg <= lnk_meta_reg;
    end
  end

  // ---------------------------------------------------------------
  // Reference clock domain: array and self-timed programming
  // ---------------------------------------------------------------
  logic [BYTE_W-1:0] mem_array [MEM_DEPTH];
  logic [BYTE_W-1:0] page_buf [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] page_mask_reg;
  logic [MEM_ADDR_W-1:0] addr_cnt_reg;
  prog_state_type prog_state_reg;
  logic [PAGE_OFFS_W-1:0] prog_idx_reg;
  logic [TIMER_W-1:0] prog_timer_reg;
  logic prog_busy;
  logic start_program;
  logic standby_reg;

  // Commit only a write that ended on a word boundary and is not protected
  assign start_program = stop_det && lnk_sync_reg[LNK_COMMIT] &&
                         !pin_sync_reg[PIN_WP] && (prog_state_reg == ps_idle);
  assign prog_busy = (prog_state_reg != ps_idle);

  // Programming sequencer: copy the page, then hold busy for the rest of the cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_state_reg <= ps_idle;
    end else begin
      unique case (prog_state_reg)
        ps_idle: begin
          if (start_program) begin
            prog_state_reg <= ps_copy;
          end
        end
        ps_copy: begin
          if (prog_idx_reg == OFFS_LAST) begin
            prog_state_reg <= ps_wait;
          end
        end
        ps_wait: begin
          if (prog_timer_reg == TIMER_ZERO) begin
            prog_state_reg <= ps_idle;
          end
        end
      endcase
    end
  end

  // Page copy index
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_idx_reg <= '0;
    end else if (prog_state_reg == ps_copy) begin
      prog_idx_reg <= prog_idx_reg + OFFS_STEP;
    end else begin
      prog_idx_reg <= '0;
    end
  end

  // Remaining cycle time after the copy
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prog_timer_reg <= '0;
    end else if (prog_state_reg == ps_copy) begin
      prog_timer_reg <= WAIT_LOAD;
    end else if (prog_timer_reg != TIMER_ZERO) begin
      prog_timer_reg <= prog_timer_reg - TIMER_STEP;
    end
  end

  // Array update: only bytes written in this transaction, page row held by the counter
  always_ff @(posedge ref_clk) begin
    if (prog_state_reg == ps_copy && page_mask_reg[prog_idx_reg]) begin
      mem_array[{addr_cnt_reg[MEM_ADDR_W-1:PAGE_OFFS_W], prog_idx_reg}] <=
        page_buf[prog_idx_reg];
    end
  end

  // Standby while the engine is parked and no programming runs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      standby_reg <= 1'h1;
    end else begin
      standby_reg <= !lnk_sync_reg[LNK_ARMED] && !prog_busy;
    end
  end

  assign standby = standby_reg;
  assign program_active = prog_busy;

  // ---------------------------------------------------------------
  // Link clock domain: word engine on the serial clock
  // ---------------------------------------------------------------
  logic [XS_W-1:0] xs_meta_reg;
  logic [XS_W-1:0] xs_sync_reg;
  logic [3:0] bit_cnt_reg;
  logic [BYTE_W-1:0] shift_reg;
  logic [BYTE_W-1:0] rx_byte;
  link_state_type link_state_reg;
  logic dev_match;
  logic ack_drive_reg;
  logic master_ack_slot_reg;
  logic [ADDR_HI_W-1:0] addr_hi_reg;
  logic pending_reg;
  logic [BYTE_W-1:0] tx_reg;
  logic [BYTE_W-1:0] mem_rd;
  logic oe_reg;

  // Busy flag and straps brought onto the serial clock
  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      xs_meta_reg <= '0;
      xs_sync_reg <= '0;
    end else begin
      xs_meta_reg <= {prog_busy, pin_sync_reg[STRAP_W-1:0]};
      xs_sync_reg <= xs_meta_reg;
    end
  end

  // Byte being completed on the eighth rising edge
  assign rx_byte = {shift_reg[BYTE_W-2:0], sda_in};
  assign dev_match = armed_reg &&
                     dev_word_match(rx_byte, xs_sync_reg[STRAP_W-1:0],
                                    xs_sync_reg[XS_BUSY]);

  // Armed from START until STOP or an address mismatch
  always_ff @(posedge scl_clk or negedge rst_b or posedge stop_pulse_reg
              or posedge start_pulse_reg) begin
    if (!rst_b) begin
      armed_reg <= 1'h0;
    end else if (stop_pulse_reg) begin
      armed_reg <= 1'h0;
    end else if (start_pulse_reg) begin
      armed_reg <= 1'h1;
    end else if (link_state_reg == ls_device && bit_cnt_reg == BIT_LAST && !dev_match) begin
      armed_reg <= 1'h0;
    end
  end

  // Nine-slot bit counter: eight data bits then the acknowledge slot
  always_ff @(posedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      bit_cnt_reg <= BIT_FIRST;
    end else if (bit_cnt_reg == ACK_SLOT) begin
      bit_cnt_reg <= BIT_FIRST;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + BIT_STEP;
    end
  end

  // Serial capture on the rising edge
  always_ff @(posedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      shift_reg <= '0;
    end else if (bit_cnt_reg != ACK_SLOT) begin
      shift_reg <= rx_byte;
    end
  end

  // Word decoder
  always_ff @(posedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      link_state_reg <= ls_device;
    end else if (bit_cnt_reg == BIT_LAST) begin
      unique case (link_state_reg)
        ls_device: begin
          if (!dev_match) begin
            link_state_reg <= ls_ignore;
          end else if (rx_byte[DEV_RW_BIT]) begin
            link_state_reg <= ls_read;
          end else begin
            link_state_reg <= ls_addr_hi;
          end
        end
        ls_addr_hi: link_state_reg <= ls_addr_lo;
        ls_addr_lo: link_state_reg <= ls_write;
        ls_write: link_state_reg <= ls_write;
        ls_read: link_state_reg <= ls_read;
        ls_ignore: link_state_reg <= ls_ignore;
      endcase
    end else if (bit_cnt_reg == ACK_SLOT && master_ack_slot_reg && sda_in) begin
      link_state_reg <= ls_ignore;
    end
  end

  // Acknowledge decision for each received word, and controller-acknowledge slot marker
  always_ff @(posedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      ack_drive_reg <= 1'h0;
      master_ack_slot_reg <= 1'h0;
    end else if (bit_cnt_reg == BIT_LAST) begin
      ack_drive_reg <= (link_state_reg == ls_device) ? dev_match :
                       (link_state_reg == ls_addr_hi || link_state_reg == ls_addr_lo ||
                        link_state_reg == ls_write);
      master_ack_slot_reg <= (link_state_reg == ls_read);
    end
  end

  // Upper memory address bits from the first address byte
  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_hi_reg <= '0;
    end else if (bit_cnt_reg == BIT_LAST && link_state_reg == ls_addr_hi) begin
      addr_hi_reg <= rx_byte[ADDR_HI_W-1:0];
    end
  end

  // Address counter, kept across transactions
  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_cnt_reg <= '0;
    end else if (bit_cnt_reg == BIT_LAST) begin
      unique case (link_state_reg)
        ls_addr_lo: addr_cnt_reg <= {addr_hi_reg, rx_byte};
        ls_write: addr_cnt_reg <= {addr_cnt_reg[MEM_ADDR_W-1:PAGE_OFFS_W],
                                   addr_cnt_reg[PAGE_OFFS_W-1:0] + OFFS_STEP};
        ls_read: addr_cnt_reg <= addr_cnt_reg + ADDR_STEP;
        ls_device, ls_addr_hi, ls_ignore: addr_cnt_reg <= addr_cnt_reg;
      endcase
    end
  end

  // Page buffer and written-byte mask; a new address clears the mask
  always_ff @(posedge scl_clk or negedge rst_b) begin
    if (!rst_b) begin
      page_mask_reg <= '0;
    end else if (bit_cnt_reg == BIT_LAST && link_state_reg == ls_addr_lo) begin
      page_mask_reg <= '0;
    end else if (bit_cnt_reg == BIT_LAST && link_state_reg == ls_write) begin
      page_mask_reg[addr_cnt_reg[PAGE_OFFS_W-1:0]] <= 1'h1;
    end
  end

  always_ff @(posedge scl_clk) begin
    if (bit_cnt_reg == BIT_LAST && link_state_reg == ls_write) begin
      page_buf[addr_cnt_reg[PAGE_OFFS_W-1:0]] <= rx_byte;
    end
  end

  // Data received in this transaction; dropped by any START or STOP
  always_ff @(posedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      pending_reg <= 1'h0;
    end else if (bit_cnt_reg == BIT_LAST && link_state_reg == ls_write) begin
      pending_reg <= 1'h1;
    end
  end

  // Commit held from the acknowledge clock through the STOP's own clock edge;
  // a second clock edge means a data bit has begun, so the write is aborted
  always_ff @(posedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      commit_ok_reg <= 1'h0;
    end else begin
      commit_ok_reg <= ((bit_cnt_reg == ACK_SLOT) && (link_state_reg == ls_write) &&
                        pending_reg) ||
                       (commit_ok_reg && (bit_cnt_reg == BIT_FIRST));
    end
  end

  // Array read for the outgoing byte; the array is still while reads are allowed
  assign mem_rd = mem_array[addr_cnt_reg];

  // Open-drain driver, updated on the falling edge only
  always_ff @(negedge scl_clk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      oe_reg <= 1'h0;
      tx_reg <= '0;
    end else if (bit_cnt_reg == ACK_SLOT) begin
      oe_reg <= ack_drive_reg;
    end else if (link_state_reg == ls_read && bit_cnt_reg == BIT_FIRST) begin
      oe_reg <= !mem_rd[BYTE_W-1];
      tx_reg <= {mem_rd[BYTE_W-2:0], 1'h0};
    end else if (link_state_reg == ls_read) begin
      oe_reg <= !tx_reg[BYTE_W-1];
      tx_reg <= {tx_reg[BYTE_W-2:0], 1'h0};
    end else begin
      oe_reg <= 1'h0;
    end
  end

  assign sda_oe = oe_reg;
  assign sda_out = 1'h0;

endmodule

// file: verification/eeprom_link_slave_assertions.sv
// Port-level assertions for the two-wire EEPROM slave
`timescale 1ns/1ps
module eeprom_link_checker #(
  parameter int PROG_CYCLES = 64
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic strap_select_bit2,
  input wire logic strap_select_bit1,
  input wire logic strap_select_bit0,
  input wire logic write_protect,
  input wire logic standby,
  input wire logic program_active
);
  int unsigned act_cnt;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  // Length of the current programming burst
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      act_cnt <= 0;
    end else begin
      act_cnt <= program_active ? act_cnt + 1 : 0;
    end
  end
  property p_out_low;
    sda_out == 1'b0;
  endproperty
  a_out_low: assert property (p_out_low) else $error("data out not low");
  property p_oe_scl_low;
    $changed(sda_oe) |-> !scl_clk;
  endproperty
  a_oe_scl_low: assert property (p_oe_scl_low) else $error("data moved, clock high");
  property p_prog_len;
    $fell(program_active) |-> act_cnt == PROG_CYCLES;
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("program length wrong");
  property p_prog_wp;
    $rose(program_active) |-> !write_protect;
  endproperty
  a_prog_wp: assert property (p_prog_wp) else $error("programmed while protected");
  property p_prog_stop;
    $rose(program_active) |-> scl_clk && sda_in;
  endproperty
  a_prog_stop: assert property (p_prog_stop) else $error("program without stop");
  property p_no_ack_busy;
    $rose(sda_oe) |-> !program_active;
  endproperty
  a_no_ack_busy: assert property (p_no_ack_busy) else $error("answer while busy");
  property p_done_standby;
    $fell(program_active) |-> ##[1:5] standby;
  endproperty
  a_done_standby: assert property (p_done_standby) else $error("no standby");
  property p_reset_idle;
    $rose(rst_b) |-> standby && !sda_oe && !program_active;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("not idle at reset");
  c_prog: cover property ($rose(program_active));
  c_ack: cover property ($rose(sda_oe));
  c_wake: cover property ($fell(standby));
endmodule

bind eeprom_link_slave eeprom_link_checker #(.PROG_CYCLES(PROG_CYCLES)) chk_u (
  .ref_clk(ref_clk), .rst_b(rst_b), .scl_clk(scl_clk), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit2(strap_select_bit2),
  .strap_select_bit1(strap_select_bit1), .strap_select_bit0(strap_select_bit0),
  .write_protect(write_protect), .standby(standby), .program_active(program_active)
);

// file: verification/bus_ctl_model.sv
// Behavioural two-wire bus controller driving the link clock and data
`timescale 1ns/1ps
module bus_ctl_model (
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda_in
);
  // Link idles with clock stopped high and data released
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end
  // One bit: data moves mid-low, sampled at the rising edge
  task automatic bit_io(input logic o, output logic i);
    #40 sda_pull = ~o;
    #40 scl_clk = 1'b1;
    i = sda_in;
    #80 scl_clk = 1'b0;
  endtask
  // Data falls with clock high, long hold for the detector
  task automatic start();
    #40 sda_pull = 1'b0;
    #40 scl_clk = 1'b1;
    #320 sda_pull = 1'b1;
    #320 scl_clk = 1'b0;
  endtask
  // Data rises with clock high, clock then stands still
  task automatic stop();
    #40 sda_pull = 1'b1;
    #40 scl_clk = 1'b1;
    #320 sda_pull = 1'b0;
    #320;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic x;
    for (int k = 7; k >= 0; k--) bit_io(b[k], x);
    bit_io(1'b1, x);
    ack = ~x;
  endtask
  task automatic rbyte(input logic ack, output logic [7:0] b);
    logic x;
    for (int k = 7; k >= 0; k--) bit_io(1'b1, b[k]);
    bit_io(~ack, x);
  endtask
endmodule

// file: verification/test_i2c_eeprom_slave_32kbit.sv
// Self-checking bench for the two-wire EEPROM slave with a byte model
`timescale 1ns/1ps
module test_i2c_eeprom_slave_32kbit;
  import eeprom_link_pkg::*;
  localparam int PROG_N = 100;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [2:0] sel = 3'h0;
  logic wp = 1'b0;
  logic scl_clk;
  logic sda_pull;
  logic sda_in;
  logic sda_out;
  logic sda_oe;
  logic standby;
  logic program_active;
  logic [7:0] mem [int];
  int ptr = 0;
  int errors = 0;
  int n_tests = 0;
  // Reference clock and open-drain data wire with pull-up
  always #20 ref_clk = ~ref_clk;
  assign sda_in = ~sda_pull & ~(sda_oe & ~sda_out);
  eeprom_link_slave #(.PROG_CYCLES(PROG_N)) dut_u (
    .ref_clk(ref_clk), .rst_b(rst_b), .scl_clk(scl_clk), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .strap_select_bit2(sel[2]),
    .strap_select_bit1(sel[1]), .strap_select_bit0(sel[0]), .write_protect(wp),
    .standby(standby), .program_active(program_active)
  );
  bus_ctl_model ctl_u (.scl_clk(scl_clk), .sda_pull(sda_pull), .sda_in(sda_in));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic idle();
    int i;
    for (i = 0; i < 50 && !standby; i++) @(negedge ref_clk);
    check(standby, 1);
    if (!standby) results();
  endtask
  task automatic dev(input logic rw, input logic [2:0] s, output logic a);
    ctl_u.start();
    ctl_u.wbyte({DEV_TYPE_CODE, s, rw}, a);
  endtask
  // Dummy write that loads the address counter
  task automatic seek(input int ad);
    logic a;
    dev(1'b0, sel, a);
    check(a, 1);
    ctl_u.wbyte({4'($urandom), 4'(ad >> 8)}, a);
    check(a, 1);
    ctl_u.wbyte(8'(ad), a);
    check(a, 1);
    ptr = ad;
  endtask
  // Wait for programming, polling once while it runs
  task automatic prog(input logic exp);
    logic s;
    logic a;
    s = 1'b0;
    for (int i = 0; i < 40 && !s; i++) @(negedge ref_clk) s = program_active;
    check(s, exp);
    if (s !== exp) results();
    if (s) begin
      dev(1'b0, sel, a);
      check(a, 0);
      ctl_u.stop();
      for (int i = 0; i < 400 && program_active; i++) @(negedge ref_clk);
      check(program_active, 0);
      if (program_active) results();
    end
    idle();
  endtask
  task automatic write(input int ad, input int n);
    logic a;
    logic [7:0] d;
    int b;
    b = ad & ~31;
    seek(ad);
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      ctl_u.wbyte(d, a);
      check(a, 1);
      if (!wp) mem[b | ((ad + i) & 31)] = d;
    end
    ptr = b | ((ad + n) & 31);
    ctl_u.stop();
    prog(!wp);
  endtask
  task automatic rd(input int n);
    logic a;
    logic [7:0] d;
    dev(1'b1, sel, a);
    check(a, 1);
    for (int i = 0; i < n; i++) begin
      ctl_u.rbyte(i < n - 1, d);
      check(d, mem[ptr]);
      ptr = (ptr + 1) % (1 << MEM_ADDR_W);
    end
    ctl_u.stop();
    idle();
  endtask
  // Main sequence
  initial begin
    logic a;
    int pg;
    void'($urandom(32'h380438ac));
    sel = 3'($urandom);
    repeat (4) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (3) @(negedge ref_clk);
    check(standby, 1);
    check(sda_oe, 0);
    dev(1'b0, sel ^ 3'h5, a);
    check(a, 0);
    ctl_u.stop();
    idle();
    pg = int'($urandom) & 12'hfe0;
    write(pg + 30, 34);
    rd(2);
    seek(pg + 28);
    rd(4);
    write(12'hfff, 1);
    write(0, 1);
    seek(12'hfff);
    rd(2);
    @(negedge ref_clk) wp = 1'b1;
    write(0, 1);
    @(negedge ref_clk) wp = 1'b0;
    seek(0);
    rd(1);
    // Abort a data byte mid-way, then the recovery sequence
    @(negedge ref_clk) sel = 3'h0;
    seek(5);
    repeat (4) ctl_u.bit_io(1'b0, a);
    ctl_u.start();
    repeat (9) ctl_u.bit_io(1'b1, a);
    ctl_u.start();
    ctl_u.stop();
    prog(0);
    seek(12'hfff);
    rd(1);
    results();
  end
endmodule
